/* src/usbhc_pkg.sv */
package usbhc_pkg;

	// Register byte offsets on the plain register port
	localparam logic [7:0] OFF_CHAR   = 8'h00; // Channel characteristics
	localparam logic [7:0] OFF_TSIZ   = 8'h04; // Channel transfer size
	localparam logic [7:0] OFF_TXDATA = 8'h08; // Transmit FIFO push (write only)
	localparam logic [7:0] OFF_RXSTAT = 8'h0C; // Receive status pop (read only)
	localparam logic [7:0] OFF_RXDATA = 8'h10; // Receive data pop (read only)
	localparam logic [7:0] OFF_EVENT  = 8'h14; // Sticky events, write one to clear
	localparam logic [7:0] OFF_STATE  = 8'h18; // Live queue and sequencer state

	// Channel characteristics fields
	localparam int CHAR_EN     = 0;  // channel_enable_bit
	localparam int CHAR_DIS    = 1;  // channel_disable_bit
	localparam int CHAR_ODD    = 2;  // odd_frame_select
	localparam int CHAR_DIR_IN = 3;  // Direction, 1 for IN
	localparam int CHAR_TYPE   = 4;  // endpoint_type_field, two bits
	localparam int CHAR_MPS    = 16; // Maximum packet size, eleven bits
	localparam logic [10:0] MPS_RST = 11'h040;

	// Channel transfer size fields
	localparam int TSIZ_XFER = 0;  // Byte count, nineteen bits
	localparam int TSIZ_PKT  = 19; // Packet count, ten bits
	localparam int TSIZ_PID  = 29; // Packet identifier, two bits
	localparam logic [1:0] PID_SETUP = 2'h3;

	// Endpoint types
	localparam logic [1:0] EP_CTRL = 2'h0;
	localparam logic [1:0] EP_BULK = 2'h2;
	localparam logic [1:0] EP_INTR = 2'h3;

	// Receive status word fields and packet_status_code values
	localparam int RXS_BCNT = 4;
	localparam int RXS_CODE = 17;
	localparam logic [3:0] STS_IN_DATA = 4'h2;
	localparam logic [3:0] STS_IN_DONE = 4'h3;
	localparam logic [3:0] STS_HALTED  = 4'h7;

	// Event register bits
	localparam int EV_TRANSFER_COMPLETE_EVENT  = 0; // transfer_complete_event
	localparam int EV_CHH   = 1; // channel_halted_event
	localparam int EV_ACK   = 2;
	localparam int EV_NAK   = 3;
	localparam int EV_STALL = 4;
	localparam int EV_TRANSACTION_ERROR_EVENT = 5; // transaction_error_event
	localparam int EV_BABB  = 6; // babble_error_event
	localparam int EV_TOGGLE_ERROR_EVENT = 7; // toggle_error_event
	localparam int EV_W     = 8;
	localparam int EV_RXLVL = 8; // rx_fifo_level_event, live
	localparam int EV_NPTXE = 9; // nonperiodic_tx_empty_event, live

	// Depths
	localparam int REQQ_DEPTH = 4;
	localparam int RX_DEPTH   = 32;
	localparam int TX_DEPTH   = 32;

	typedef enum logic [1:0] {REQ_OUT = 2'b00, REQ_IN = 2'b01, REQ_HALT = 2'b11} usbhc_req_e;
	typedef enum logic [1:0] {TOK_OUT = 2'b00, TOK_IN = 2'b01, TOK_SETUP = 2'b10} usbhc_tok_e;
	typedef enum logic [2:0] {
		RSP_ACK = 3'h0, RSP_NAK = 3'h1, RSP_STALL = 3'h2,
		RSP_TRANSACTION_ERROR_EVENT = 3'h3, RSP_BABBLE = 3'h4, RSP_TOGGLE_ERROR_EVENT = 3'h5
	} usbhc_rsp_e;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_BUSY = 2'b01} usbhc_state_e;

endpackage

/* src/usbhc_reqq.sv */
`timescale 1ns/10ps
`default_nettype none

// Small request queue; flush empties it, a push in the same cycle survives
module usbhc_reqq
	import usbhc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       flush,
	input  wire logic       push,
	input  wire usbhc_req_e push_kind,
	input  wire logic       pop,
	output usbhc_req_e      head_kind,
	output logic            not_empty,
	output logic            full,
	output logic [2:0]      count
);
	usbhc_req_e mem [REQQ_DEPTH]; // Entry storage
	logic [1:0] wr_ptr;           // Next free slot
	logic [1:0] rd_ptr;           // Oldest entry

	assign head_kind = mem[rd_ptr];
	assign not_empty = (count != 3'h0);
	assign full      = (count == 3'h4);

	// Entry store; a push into a full queue is dropped
	always_ff @(posedge clk) begin
		if (flush && push) begin
			mem[2'h0] <= push_kind;
		end else if (push && !full) begin
			mem[wr_ptr] <= push_kind;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr <= 2'h0;
			rd_ptr <= 2'h0;
			count  <= 3'h0;
		end else if (flush) begin
			// Flushing drops every queued request; a same-cycle push is kept
			wr_ptr <= push ? 2'h1 : 2'h0;
			rd_ptr <= 2'h0;
			count  <= push ? 3'h1 : 3'h0;
		end else begin
			if (push && !full) begin
				wr_ptr <= wr_ptr + 2'h1;
			end
			if (pop && not_empty) begin
				rd_ptr <= rd_ptr + 2'h1;
			end
			count <= count + 3'((push && !full) ? 1 : 0) - 3'((pop && not_empty) ? 1 : 0);
		end
	end

	no_overflow_a: assert property (@(posedge clk) disable iff (sys_rst) count <= 3'h4)
		else $error("request queue count beyond depth");

endmodule

`default_nettype wire

/* src/usbhc_channel.sv */
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// (RULE1) Software drops statuses other than IN data
// (RULE2) Last OUT packet word posts nonperiodic request
// (RULE3) Queued request issues token in current frame
// (RULE4) Last successful OUT transaction raises transfer complete
// (RULE5) SETUP runs as single-packet bulk OUT
// (RULE6) Enable write on IN channel posts request
// (RULE7) Queued IN waits for running OUT
// (RULE8) Stored IN packet raises receive level event
// (RULE9) Software masks, reads status, data, unmasks
// (RULE10) Completion status entry follows last IN packet
// (RULE11) Reading completion status raises transfer complete
// (RULE12) Disable write posts channel disable request
// (RULE13) Halt writes halt status into receive FIFO
// (RULE14) Popping halt status raises channel halted
// (RULE15) Control stages run as three transfers
// (RULE16) Setup stage programs SETUP packet identifier
// (RULE17) Odd-frame interrupt OUT waits for odd frame
// (RULE18) Interrupt OUT last word posts periodic request
// (RULE19) Interrupt OUT completion raises transfer complete
// (RULE20) Software frees channel after three errors
// (RULE21) Software rewinds and disables on OUT errors
// (RULE22) Software disables IN channel on errors
// (RULE23) Software writes OUT data only with room
// (RULE24) Software writes transmit FIFO in words
// (RULE25) Enable plus disable flushes and halts channel
module usbhc_channel
	import usbhc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	output logic             tok_valid,
	output usbhc_tok_e       tok_pid,
	output logic [10:0]      tok_len,
	input  wire logic        tx_pop,
	output logic [31:0]      tx_word,
	input  wire logic        rx_valid,
	input  wire logic [31:0] rx_word,
	input  wire logic [10:0] rx_len,
	output logic             rx_ready,
	input  wire logic        link_done,
	input  wire usbhc_rsp_e  link_rsp,
	input  wire logic        frame_odd,
	output logic             rx_fifo_level_event,
	output logic             nonperiodic_tx_empty_event
);
	// Channel characteristics and transfer size state
	logic        chan_en;      // channel_enable_bit as held
	logic        odd_sel;      // odd_frame_select
	logic        dir_in;       // IN direction
	logic [1:0]  ep_type;      // endpoint_type_field
	logic [10:0] mps;          // Maximum packet size
	logic [18:0] xfer_bytes;   // Bytes still to transfer
	logic [9:0]  pkt_cnt;      // Packets still to transfer
	logic [1:0]  pid_sel;      // Packet identifier field
	logic [18:0] post_bytes;   // Bytes not yet posted as OUT packets
	logic [10:0] fill_bytes;   // Bytes written into the open OUT packet
	logic [EV_W-1:0] events;   // Sticky events
	usbhc_state_e state;       // Sequencer state

	// Transmit FIFO
	logic [31:0] tx_mem [TX_DEPTH];
	logic [4:0]  tx_wp;
	logic [4:0]  tx_rp;
	logic [5:0]  tx_cnt;

	// Receive FIFO, bit 32 marks a status entry
	logic [32:0] rx_mem [RX_DEPTH];
	logic [4:0]  rx_wp;
	logic [4:0]  rx_rp;
	logic [5:0]  rx_cnt;
	logic [5:0]  stat_ready;   // Status entries whose packet is closed
	logic        hdr_done;     // Status word of the open IN packet written
	logic [10:0] rx_got;       // Byte count of the open IN packet

	// Request queue wiring
	logic       np_push, pq_push, np_pop, pq_pop, np_ne, pq_ne, np_full;
	usbhc_req_e np_kind, pq_kind, push_kind, np_head, pq_head;
	logic [2:0] np_cnt, pq_cnt;

	// Decoded register strobes
	logic        wr_char, wr_tsiz, wr_tx, rd_stat, rd_data, flush;
	logic        pkt_last, is_intr, pq_go, head_is_stat;
	logic [10:0] cur_len;
	logic [3:0]  head_code;
	logic        rx_push;
	logic [32:0] rx_entry;
	logic        halt_pop, done_ack;

	// Smaller of remaining bytes and packet size
	function automatic logic [10:0] pkt_len(input logic [18:0] rem, input logic [10:0] m);
		pkt_len = (rem < {8'h00, m}) ? rem[10:0] : m;
	endfunction

	assign wr_char  = reg_wr && (reg_addr == OFF_CHAR);
	assign wr_tsiz  = reg_wr && (reg_addr == OFF_TSIZ);
	assign wr_tx    = reg_wr && (reg_addr == OFF_TXDATA);
	assign head_is_stat = rx_mem[rx_rp][32];
	assign head_code    = rx_mem[rx_rp][RXS_CODE+3:RXS_CODE];
	assign rd_stat  = reg_rd && (reg_addr == OFF_RXSTAT) && (stat_ready != 6'h0) && head_is_stat;
	assign rd_data  = reg_rd && (reg_addr == OFF_RXDATA) && (rx_cnt != 6'h0) && !head_is_stat;
	assign flush    = wr_char && reg_wdata[CHAR_EN] && reg_wdata[CHAR_DIS]; // [RULE25]
	assign is_intr  = (ep_type == EP_INTR);
	assign cur_len  = pkt_len(post_bytes, mps);
	assign pkt_last = wr_tx && ((fill_bytes + 11'h004) >= cur_len);

	// Posting: disable and IN on a characteristics write, OUT on the last word
	always_comb begin
		np_push   = 1'b0;
		pq_push   = 1'b0;
		push_kind = REQ_OUT;
		if (flush) begin
			push_kind = REQ_HALT; // [RULE12]
			np_push   = !is_intr;
			pq_push   = is_intr;
		end else if (wr_char && reg_wdata[CHAR_EN] && reg_wdata[CHAR_DIR_IN]) begin
			push_kind = REQ_IN; // [RULE6]
			np_push   = 1'b1;
		end else if (pkt_last && !dir_in) begin
			np_push = !is_intr; // [RULE2] [RULE5]
			pq_push = is_intr;  // [RULE18]
		end
	end
	assign np_kind = push_kind;
	assign pq_kind = push_kind;

	// Periodic head goes only in the selected frame parity
	assign pq_go  = pq_ne && (frame_odd == odd_sel); // [RULE17]
	assign np_pop = (state == ST_IDLE) && np_ne && !pq_go; // [RULE3] [RULE7]
	assign pq_pop = (state == ST_IDLE) && pq_go;
	assign halt_pop = (np_pop && np_head == REQ_HALT) || (pq_pop && pq_head == REQ_HALT);
	assign done_ack = (state == ST_BUSY) && link_done && (link_rsp == RSP_ACK);

	usbhc_reqq u_npq (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.flush     (flush),
		.push      (np_push),
		.push_kind (np_kind),
		.pop       (np_pop),
		.head_kind (np_head),
		.not_empty (np_ne),
		.full      (np_full),
		.count     (np_cnt)
	);

	usbhc_reqq u_pq (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.flush     (flush),
		.push      (pq_push),
		.push_kind (pq_kind),
		.pop       (pq_pop),
		.head_kind (pq_head),
		.not_empty (pq_ne),
		// Periodic fill level is visible in the state word; no flag needs it full
		.full      (),
		.count     (pq_cnt)
	);

	// Software-written channel setup
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			odd_sel <= 1'b0;
			dir_in  <= 1'b0;
			ep_type <= EP_CTRL;
			mps     <= MPS_RST;
			pid_sel <= 2'h0;
		end else begin
			if (wr_char) begin
				odd_sel <= reg_wdata[CHAR_ODD];
				dir_in  <= reg_wdata[CHAR_DIR_IN];
				ep_type <= reg_wdata[CHAR_TYPE+1:CHAR_TYPE];
				mps     <= reg_wdata[CHAR_MPS+10:CHAR_MPS];
			end
			if (wr_tsiz) begin
				pid_sel <= reg_wdata[TSIZ_PID+1:TSIZ_PID];
			end
		end
	end

	// Enable tracks software until the disable request is served
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			chan_en <= 1'b0;
		end else if (wr_char) begin
			chan_en <= reg_wdata[CHAR_EN];
		end else if (halt_pop) begin
			chan_en <= 1'b0;
		end
	end

	// Remaining bytes and packets, counted down on each ACK
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			xfer_bytes <= 19'h0;
			pkt_cnt    <= 10'h0;
		end else if (wr_tsiz) begin
			xfer_bytes <= reg_wdata[TSIZ_XFER+18:TSIZ_XFER];
			pkt_cnt    <= reg_wdata[TSIZ_PKT+9:TSIZ_PKT];
		end else if (done_ack) begin
			xfer_bytes <= xfer_bytes - {8'h00, dir_in ? rx_got : tok_len};
			pkt_cnt    <= (pkt_cnt != 10'h0) ? pkt_cnt - 10'h1 : 10'h0;
		end
	end

	// Packet framing of software words; padding in the last word is counted whole
	always_ff @(posedge clk) begin
		if (sys_rst || flush) begin
			post_bytes <= 19'h0;
			fill_bytes <= 11'h0;
		end else if (wr_tsiz) begin
			post_bytes <= reg_wdata[TSIZ_XFER+18:TSIZ_XFER];
			fill_bytes <= 11'h0;
		end else if (pkt_last) begin
			post_bytes <= post_bytes - {8'h00, cur_len};
			fill_bytes <= 11'h0;
		end else if (wr_tx) begin
			fill_bytes <= fill_bytes + 11'h004;
		end
	end

	// Transmit FIFO storage; a word into a full FIFO is dropped
	always_ff @(posedge clk) begin
		if (wr_tx && tx_cnt != 6'(TX_DEPTH)) begin
			tx_mem[tx_wp] <= reg_wdata;
		end
	end

	// Transmit FIFO pointers; flushing also discards unsent data
	always_ff @(posedge clk) begin
		if (sys_rst || flush) begin
			tx_wp  <= 5'h0;
			tx_rp  <= 5'h0;
			tx_cnt <= 6'h0;
		end else begin
			if (wr_tx && tx_cnt != 6'(TX_DEPTH)) begin
				tx_wp <= tx_wp + 5'h1;
			end
			if (tx_pop && tx_cnt != 6'h0) begin
				tx_rp <= tx_rp + 5'h1;
			end
			tx_cnt <= tx_cnt + 6'((wr_tx && tx_cnt != 6'(TX_DEPTH)) ? 1 : 0)
				- 6'((tx_pop && tx_cnt != 6'h0) ? 1 : 0);
		end
	end

	// Registered word at the FIFO head; looks one ahead on a pop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_word <= 32'h0;
		end else begin
			tx_word <= tx_pop ? tx_mem[tx_rp + 5'h1] : tx_mem[tx_rp];
		end
	end

	// Sequencer: one transaction on the link at a time
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state     <= ST_IDLE;
			tok_valid <= 1'b0;
			tok_pid   <= TOK_OUT;
			tok_len   <= 11'h0;
		end else begin
			case (state)
				ST_IDLE: begin
					// A halt request ends the channel without a token
					if ((np_pop || pq_pop) && !halt_pop) begin
						state     <= ST_BUSY; // [RULE3]
						tok_valid <= 1'b1;
						tok_len   <= pkt_len(xfer_bytes, mps);
						if (dir_in) begin
							tok_pid <= TOK_IN;
						end else if (pid_sel == PID_SETUP) begin
							tok_pid <= TOK_SETUP; // [RULE5]
						end else begin
							tok_pid <= TOK_OUT;
						end
					end
				end
				ST_BUSY: begin
					// Started transactions are never cut short by a flush
					if (link_done) begin
						state     <= ST_IDLE;
						tok_valid <= 1'b0;
					end
				end
				default: begin
					state     <= ST_IDLE;
					tok_valid <= 1'b0;
				end
			endcase
		end
	end

	// Receive FIFO write selection: halt, IN status word, IN data, completion
	assign rx_ready = (state == ST_BUSY) && hdr_done && (rx_cnt != 6'(RX_DEPTH));
	always_comb begin
		rx_push  = 1'b0;
		rx_entry = 33'h0;
		if (halt_pop && rx_cnt != 6'(RX_DEPTH)) begin
			rx_push  = 1'b1; // [RULE13]
			rx_entry = {1'b1, 32'(STS_HALTED) << RXS_CODE};
		end else if (state == ST_BUSY && rx_valid && !hdr_done && rx_cnt != 6'(RX_DEPTH)) begin
			rx_push  = 1'b1;
			rx_entry = {1'b1, (32'(STS_IN_DATA) << RXS_CODE) | (32'(rx_len) << RXS_BCNT)};
		end else if (rx_valid && rx_ready) begin
			rx_push  = 1'b1;
			rx_entry = {1'b0, rx_word};
		end else if (done_ack && dir_in && rx_cnt != 6'(RX_DEPTH)
			&& (pkt_cnt == 10'h1 || rx_got < mps)) begin
			rx_push  = 1'b1; // [RULE10]
			rx_entry = {1'b1, 32'(STS_IN_DONE) << RXS_CODE};
		end
	end

	always_ff @(posedge clk) begin
		if (rx_push) begin
			rx_mem[rx_wp] <= rx_entry;
		end
	end

	// Receive FIFO pointers and the open-packet header flag
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_wp    <= 5'h0;
			rx_rp    <= 5'h0;
			rx_cnt   <= 6'h0;
			hdr_done <= 1'b0;
			rx_got   <= 11'h0;
		end else begin
			if (rx_push) begin
				rx_wp <= rx_wp + 5'h1;
			end
			if (rd_stat || rd_data) begin
				rx_rp <= rx_rp + 5'h1;
			end
			rx_cnt <= rx_cnt + 6'(rx_push ? 1 : 0) - 6'((rd_stat || rd_data) ? 1 : 0);
			if (state == ST_BUSY && link_done) begin
				hdr_done <= 1'b0;
			end else if (state == ST_BUSY && rx_valid && !hdr_done && rx_push) begin
				hdr_done <= 1'b1;
				rx_got   <= rx_len;
			end
			if (np_pop || pq_pop) begin
				rx_got <= 11'h0;
			end
		end
	end

	// Status entries become visible only once their packet is closed
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stat_ready <= 6'h0;
		end else begin
			stat_ready <= stat_ready
				+ 6'((state == ST_BUSY && link_done && hdr_done) ? 1 : 0) // [RULE8]
				+ 6'((rx_push && rx_entry[32] && (halt_pop || done_ack)) ? 1 : 0)
				- 6'(rd_stat ? 1 : 0);
		end
	end

	assign rx_fifo_level_event        = (stat_ready != 6'h0); // [RULE8]
	assign nonperiodic_tx_empty_event = (tx_cnt == 6'h0) && !np_full;

	// Sticky events; a new event wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			events <= '0;
		end else begin
			events <= (events & ~((reg_wr && reg_addr == OFF_EVENT) ? reg_wdata[EV_W-1:0] : '0))
				| EV_W'(((done_ack && !dir_in && pkt_cnt == 10'h1) || (rd_stat && head_code == STS_IN_DONE))
					? 8'h01 << EV_TRANSFER_COMPLETE_EVENT : 8'h00) // [RULE4] [RULE11] [RULE19]
				| EV_W'((rd_stat && head_code == STS_HALTED) ? 8'h01 << EV_CHH : 8'h00) // [RULE14]
				| EV_W'((state == ST_BUSY && link_done) ? 8'h01 << (EV_ACK + 32'(link_rsp)) : 8'h00);
		end
	end

	// Read data, one cycle after the strobe; unmapped addresses read zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
				OFF_CHAR:   reg_rdata <= (32'(mps) << CHAR_MPS) | (32'(ep_type) << CHAR_TYPE)
					| (32'(dir_in) << CHAR_DIR_IN) | (32'(odd_sel) << CHAR_ODD) | 32'(chan_en);
				OFF_TSIZ:   reg_rdata <= (32'(pid_sel) << TSIZ_PID) | (32'(pkt_cnt) << TSIZ_PKT)
					| 32'(xfer_bytes);
				OFF_RXSTAT: reg_rdata <= rd_stat ? rx_mem[rx_rp][31:0] : 32'h0;
				OFF_RXDATA: reg_rdata <= rd_data ? rx_mem[rx_rp][31:0] : 32'h0;
				OFF_EVENT:  reg_rdata <= (32'(nonperiodic_tx_empty_event) << EV_NPTXE)
					| (32'(rx_fifo_level_event) << EV_RXLVL) | 32'(events);
				OFF_STATE:  reg_rdata <= {12'h0, state, tx_cnt, rx_cnt, pq_cnt, np_cnt};
				default:    reg_rdata <= 32'h0;
			endcase
		end
	end

	// Checks
	out_post_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
		(pkt_last && !dir_in && !is_intr && !wr_char) |-> np_push && np_kind == REQ_OUT)
		else $error("OUT packet end did not post a request");
	intr_post_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE18]
		(pkt_last && !dir_in && is_intr && !wr_char) |-> pq_push && !np_push)
		else $error("interrupt OUT packet end did not post periodic request");
	in_post_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
		(wr_char && reg_wdata[CHAR_EN] && !reg_wdata[CHAR_DIS] && reg_wdata[CHAR_DIR_IN])
		|-> np_push && np_kind == REQ_IN)
		else $error("enable write did not post IN request");
	issue_now_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
		(state == ST_IDLE && np_ne && !pq_ne) |-> np_pop)
		else $error("queued request not issued");
	one_txn_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
		(state == ST_BUSY) |-> !np_pop && !pq_pop ##0 tok_valid)
		else $error("request popped while a transaction runs");
	odd_frame_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE17]
		pq_pop |-> frame_odd == odd_sel)
		else $error("periodic request issued in wrong frame parity");
	out_done_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
		(done_ack && !dir_in && pkt_cnt == 10'h1) |=> events[EV_TRANSFER_COMPLETE_EVENT] && pkt_cnt == 10'h0)
		else $error("last OUT packet did not raise transfer complete");
	in_level_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
		(state == ST_BUSY && link_done && hdr_done && !rd_stat) |=> rx_fifo_level_event)
		else $error("stored IN packet did not raise level event");
	cmpl_read_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
		(rd_stat && head_code == STS_IN_DONE) |=> events[EV_TRANSFER_COMPLETE_EVENT])
		else $error("completion status read did not raise transfer complete");
	halt_entry_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
		(halt_pop && rx_cnt < 6'h20 && !rd_stat) |=> rx_fifo_level_event && !chan_en)
		else $error("halt did not queue a halt status");
	halt_event_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE14]
		(rd_stat && head_code == STS_HALTED) |=> events[EV_CHH])
		else $error("halt status pop did not raise channel halted");
	flush_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE25]
		flush |=> (np_cnt + pq_cnt) == 3'h1 && tx_cnt == 6'h0)
		else $error("disable write did not flush requests");
	out_txn_c: cover property (@(posedge clk) disable iff (sys_rst) done_ack && !dir_in && pkt_cnt == 10'h1);
	in_cmpl_c: cover property (@(posedge clk) disable iff (sys_rst) rd_stat && head_code == STS_IN_DONE);
	halt_c:    cover property (@(posedge clk) disable iff (sys_rst) rd_stat && head_code == STS_HALTED);
	odd_c:     cover property (@(posedge clk) disable iff (sys_rst) pq_pop && !halt_pop);

endmodule

`default_nettype wire

/* dv/usbhc_link_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Device on the far side of the link: answers each token, after lag cycles
module usbhc_link_model
	import usbhc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        tok_valid,
	input  wire usbhc_tok_e  tok_pid,
	input  wire logic [10:0] tok_len,
	input  wire logic [31:0] tx_word,
	input  wire logic        rx_ready,
	input  wire logic [3:0]  lag,
	input  wire usbhc_rsp_e  rsp,
	output logic             tx_pop,
	output logic             rx_valid,
	output logic [31:0]      rx_word,
	output logic [10:0]      rx_len,
	output logic             link_done,
	output usbhc_rsp_e       link_rsp
);
	logic [31:0] got [$]; // OUT words seen on the wire
	int          n;       // Words left in this packet
	// One transaction at a time; data line inverted once released
	initial begin
		{tx_pop, rx_valid, link_done, rx_len} = '0;
		rx_word  = 32'h0;
		link_rsp = RSP_ACK;
		forever begin
			@(posedge clk iff tok_valid);
			repeat (lag) @(posedge clk);
			n = (int'(tok_len) + 3) / 4;
			if (tok_pid == TOK_IN) begin
				rx_len   <= tok_len;
				rx_valid <= 1'b1;
				rx_word  <= 32'hD000_0000;
				while (n > 0) begin
					@(posedge clk);
					if (rx_ready) begin
						n--;
						// The released data line shows the inverse of the last word
						rx_word <= (n > 0) ? rx_word + 32'h1 : ~rx_word;
					end
				end
				rx_valid <= 1'b0;
			end else begin
				// Pop whole words; the head word is taken at the pop edge
				while (n > 0) begin
					tx_pop <= 1'b1;
					@(posedge clk);
					got.push_back(tx_word);
					n--;
				end
				tx_pop <= 1'b0;
			end
			link_done <= 1'b1;
			link_rsp  <= rsp;
			@(posedge clk);
			link_done <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb import usbhc_pkg::*;;
	logic        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, frame_odd = 0;
	logic [3:0]  lag = 4'h0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, tx_word, rx_word;
	logic        tok_valid, tx_pop, rx_valid, rx_ready, link_done, rx_fifo_level_event, nonperiodic_tx_empty_event;
	usbhc_tok_e  tok_pid;
	usbhc_rsp_e  link_rsp, rsp = RSP_ACK;
	logic [10:0] tok_len, rx_len;
	int          n_errors = 0, tests_run = 0;
	always #20 clk = ~clk;
	usbhc_channel i_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tok_valid, .tok_pid,
		.tok_len, .tx_pop, .tx_word, .rx_valid, .rx_word, .rx_len, .rx_ready, .link_done, .link_rsp, .frame_odd,
		.rx_fifo_level_event, .nonperiodic_tx_empty_event);
	usbhc_link_model i_link (.clk, .tok_valid, .tok_pid, .tok_len, .tx_word, .rx_ready, .lag, .tx_pop, .rx_valid,
		.rx_word, .rx_len, .link_done, .link_rsp, .rsp);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read, then compare the masked data at the falling edge after it is registered; it holds until the next read
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata & m, exp);
	endtask
	// Bounded wait for the level event (1) or a token (0)
	task automatic await(input bit lvl);
		int i;
		for (i = 0; i < 200; i++) begin
			@(negedge clk);
			if ((lvl ? rx_fifo_level_event : tok_valid) === 1'b1) break;
		end
		chk({31'h0, i < 200}, 32'h1);
	endtask
	task automatic tok(input usbhc_tok_e p, input logic [10:0] l);
		await(0);
		chk({19'h0, tok_pid, tok_len}, {19'h0, p, l});
		while (tok_valid === 1'b1) @(negedge clk);
	endtask
	// OUT packets of two words each, mps 8
	task automatic t_out(input logic [1:0] ty, input logic [1:0] pid, input int pk, input bit odd);
		wr(OFF_TSIZ, {1'b0, pid, 10'(pk), 19'(pk * 8)});
		wr(OFF_CHAR, {5'h0, 11'h008, 10'h0, ty, 1'b0, odd, 2'h1});
		for (int k = 0; k < pk; k++) begin
			wr(OFF_TXDATA, 32'hA000_0000 + k);
			repeat (3) @(negedge clk);
			chk({31'h0, tok_valid}, 32'h0);
			wr(OFF_TXDATA, 32'hB000_0000 + k);
			if (odd) begin
				repeat (4) @(negedge clk);
				chk({31'h0, tok_valid}, 32'h0);
				@(posedge clk);
				frame_odd <= 1'b1;
			end
			tok(pid == PID_SETUP ? TOK_SETUP : TOK_OUT, 11'h008);
			chk(i_link.got.pop_front(), 32'hA000_0000 + k);
			chk(i_link.got.pop_front(), 32'hB000_0000 + k);
			rdc(OFF_EVENT, 32'h1, {31'h0, k == pk - 1});
		end
		wr(OFF_EVENT, 32'h0000_00FF);
	endtask
	// Bulk IN, one 8-byte packet, then halt
	task automatic t_in;
		wr(OFF_TSIZ, 32'h0008_0008);
		wr(OFF_CHAR, {5'h0, 11'h008, 10'h0, EP_BULK, 4'h9});
		tok(TOK_IN, 11'h008);
		await(1);
		rdc(OFF_RXSTAT, 32'h001E_7FF0, 32'h0004_0080);
		rdc(OFF_RXDATA, 32'hFFFF_FFFF, 32'hD000_0000);
		rdc(OFF_RXDATA, 32'hFFFF_FFFF, 32'hD000_0001);
		await(1);
		rdc(OFF_EVENT, 32'h1, 32'h0);
		rdc(OFF_RXSTAT, 32'h001E_0000, 32'h0006_0000);
		rdc(OFF_EVENT, 32'h1, 32'h1);
		wr(OFF_CHAR, {5'h0, 11'h008, 10'h0, EP_BULK, 4'hB});
		await(1);
		rdc(OFF_EVENT, 32'h2, 32'h0);
		rdc(OFF_RXSTAT, 32'h001E_0000, 32'h000E_0000);
		rdc(OFF_EVENT, 32'h2, 32'h2);
		rdc(OFF_RXSTAT, 32'hFFFF_FFFF, 32'h0);
		wr(OFF_EVENT, 32'h0000_00FF);
	endtask
	// Failed transaction: software disables the channel, drains, reads the halt
	task automatic t_err(input bit is_in, input usbhc_rsp_e r);
		rsp <= r;
		wr(OFF_TSIZ, 32'h0008_0008);
		wr(OFF_CHAR, {5'h0, 11'h008, 10'h0, EP_BULK, is_in, 3'h1});
		if (!is_in) begin
			rdc(OFF_EVENT, 32'h200, 32'h200);
			wr(OFF_TXDATA, 32'hC000_0000);
			wr(OFF_TXDATA, 32'hC000_0001);
		end
		tok(is_in ? TOK_IN : TOK_OUT, 11'h008);
		rdc(OFF_EVENT, 32'hFF, 32'h1 << (EV_ACK + r));
		wr(OFF_CHAR, {5'h0, 11'h008, 10'h0, EP_BULK, is_in, 3'h3});
		rsp <= RSP_ACK;
		if (is_in) begin
			rdc(OFF_RXSTAT, 32'h001E_0000, 32'h0004_0000);
			rdc(OFF_RXDATA, 32'hFFFF_FFFF, 32'hD000_0000);
			rdc(OFF_RXDATA, 32'hFFFF_FFFF, 32'hD000_0001);
		end else begin
			chk(i_link.got.pop_front(), 32'hC000_0000);
			chk(i_link.got.pop_front(), 32'hC000_0001);
		end
		await(1);
		rdc(OFF_RXSTAT, 32'h001E_0000, 32'h000E_0000);
		rdc(OFF_EVENT, 32'h2, 32'h2);
		wr(OFF_EVENT, 32'h0000_00FF);
	endtask
	task automatic finish_test;
		if (n_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial begin
		#400000;
		n_errors++;
		finish_test;
	end
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rdc(OFF_EVENT, 32'hFFFF_FFFF, 32'h0000_0200);
		rdc(OFF_CHAR, 32'hFFFF_FFFF, 32'h0040_0000);
		rdc(8'h40, 32'hFFFF_FFFF, 32'h0);
		t_out(EP_BULK, 2'h0, 2, 1'b0);
		lag <= 4'h3;
		t_out(EP_CTRL, PID_SETUP, 1, 1'b0);
		lag <= 4'h0;
		t_in;
		t_err(1'b0, RSP_NAK);
		t_err(1'b1, RSP_TRANSACTION_ERROR_EVENT);
		t_out(EP_INTR, 2'h0, 1, 1'b1);
		finish_test;
	end
endmodule
`default_nettype wire
